// ==== pil_pkg.sv ====
package pil_pkg;
  // System clock rate
  localparam int unsigned CLK_KHZ = 250000;
  // Switching frequencies
  localparam int unsigned FSW0_KHZ = 500;
  localparam int unsigned FSW1_KHZ = 750;
  localparam int unsigned FSW2_KHZ = 1000;
  // Counter widths
  localparam int PER_W = 10;
  localparam int MCNT_W = 12;
  // Whole and fractional part of each switching period
  localparam logic [PER_W-1:0] PER0 = PER_W'(CLK_KHZ / FSW0_KHZ);
  localparam logic [PER_W-1:0] PER1 = PER_W'(CLK_KHZ / FSW1_KHZ);
  localparam logic [PER_W-1:0] PER2 = PER_W'(CLK_KHZ / FSW2_KHZ);
  localparam logic [PER_W-1:0] REM0 = PER_W'(CLK_KHZ % FSW0_KHZ);
  localparam logic [PER_W-1:0] REM1 = PER_W'(CLK_KHZ % FSW1_KHZ);
  localparam logic [PER_W-1:0] REM2 = PER_W'(CLK_KHZ % FSW2_KHZ);
  localparam logic [PER_W-1:0] DEN0 = PER_W'(FSW0_KHZ);
  localparam logic [PER_W-1:0] DEN1 = PER_W'(FSW1_KHZ);
  localparam logic [PER_W-1:0] DEN2 = PER_W'(FSW2_KHZ);
  // Frequency codes
  localparam logic [2:0] FRQ_500 = 3'h0;
  localparam logic [2:0] FRQ_750 = 3'h1;
  localparam logic [2:0] FRQ_1000 = 3'h2;
  // Frequency and interleave register layout
  localparam int FRQ_MSB = 7;
  localparam int FRQ_LSB = 5;
  localparam int ILV_MSB = 4;
  localparam int ILV_LSB = 0;
  localparam logic [7:0] FP_RESET = 8'h00;
  // Duty cap register layout
  localparam int CAP_MSB = 7;
  localparam int CAP_LSB = 2;
  localparam int HI_BIT = 1;
  localparam int LO_BIT = 0;
  localparam logic [7:0] DC_RESET = 8'hE8;
  // Duty denominator and interleave steps per cycle
  localparam int unsigned DUTY_DEN = 192;
  localparam int ILV_SHIFT = 5;
  // Register select codes
  localparam logic REG_FREQ_PHASE = 1'b0;
  localparam logic REG_DUTY_CAP = 1'b1;
  // Master clock watch
  localparam int unsigned MASTER_KHZ = 250;
  localparam logic [MCNT_W-1:0] MASTER_CYC =
    MCNT_W'(CLK_KHZ / MASTER_KHZ);
  localparam logic [MCNT_W-1:0] MASTER_TOL = 12'h008;
  localparam logic [2:0] LOCK_EDGES = 3'h4;
  // Duty integrator: 6 integer bits, 8 fraction bits
  localparam int ACC_W = 14;
  localparam int ACC_FRAC = 8;
  localparam int GAIN_SHIFT = 2;
  localparam logic signed [7:0] WINDOW_LIM = 8'sh20;
  // Controller states
  typedef enum logic [1:0] {PIL_IDLE, PIL_WAIT_LOCK, PIL_RUN} pil_state_t;
endpackage

// ==== pil_sync_lock.sv ====
// Watches sync edges and reports lock to the master clock
module pil_sync_lock
  import pil_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sync line
  input wire logic sync_line,
  // Status
  output logic sync_edge,
  output logic locked
);
  logic sync_q, sync_d;
  logic edge_q, edge_d;
  logic lock_q, lock_d;
  logic [MCNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] good_q, good_d;
  logic in_tol;

  // Period check against the expected master period
  assign in_tol = (cnt_q + MCNT_W'(1) >= MASTER_CYC - MASTER_TOL) &&
                  (cnt_q + MCNT_W'(1) <= MASTER_CYC + MASTER_TOL);

  // Edge detection, period count and lock decision
  always_comb begin
    sync_d = sync_line;
    edge_d = sync_line & ~sync_q;
    cnt_d = cnt_q;
    good_d = good_q;
    lock_d = lock_q;
    if (edge_d) begin
      cnt_d = '0;
      if (in_tol) begin
        if (good_q != LOCK_EDGES) begin
          good_d = good_q + 3'h1;
        end
      end else begin
        good_d = '0;
      end
    end else if (cnt_q > MASTER_CYC + MASTER_TOL) begin
      good_d = '0; // Master clock missing
    end else begin
      cnt_d = cnt_q + MCNT_W'(1);
    end
    lock_d = (good_d == LOCK_EDGES);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
      edge_q <= 1'b0;
      lock_q <= 1'b0;
      cnt_q <= '0;
      good_q <= '0;
    end else begin
      sync_q <= sync_d;
      edge_q <= edge_d;
      lock_q <= lock_d;
      cnt_q <= cnt_d;
      good_q <= good_d;
    end
  end

  assign sync_edge = edge_q;
  assign locked = lock_q;
endmodule

// ==== pil_pwm.sv ====
// Interleaved PWM with duty cap and saturation feedforward
module pil_pwm
  import pil_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link to the power manager
  input wire logic sync_line,
  // Converter control
  input wire logic load_converter,
  input wire logic phase_default_select_input,
  input wire logic [4:0] device_address,
  input wire logic signed [7:0] reg_error,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] switch_frequency_phase,
  output logic [7:0] duty_cap_saturation_ctrl,
  // Outputs
  output logic pwm_out,
  output logic pll_locked
);
  logic sync_edge, locked;
  logic [7:0] fp_q, fp_d, dc_q, dc_d;
  logic strap_q, strap_d;
  pil_state_t st_q, st_d;
  logic [2:0] frq_q, frq_d;
  logic [4:0] ilv_q, ilv_d;
  logic [PER_W-1:0] pos_q, pos_d, per_q, per_d, off_q, off_d;
  logic [PER_W-1:0] acc_q, acc_d, duty_q, duty_d;
  logic [ACC_W-1:0] dacc_q, dacc_d;
  logic pwm_q, pwm_d, lk_q;
  logic [PER_W-1:0] base, rem, den, rel;
  logic [ACC_W-1:0] cap_acc;
  logic [ACC_W-1:0] dnext;
  logic [ACC_W:0] sum;
  logic [PER_W+5:0] dprod;
  logic [PER_W+4:0] oprod;
  logic wrap, hi_sat, lo_sat;

  pil_sync_lock u_lock (
    .sys_clk(sys_clk),
    .rst(rst),
    .sync_line(sync_line),
    .sync_edge(sync_edge),
    .locked(locked)
  );

  // Register file with frequency/phase write protection and reset strap
  always_comb begin
    fp_d = fp_q;
    dc_d = dc_q;
    strap_d = 1'b1;
    if (!strap_q) begin
      fp_d[ILV_MSB:ILV_LSB] = phase_default_select_input ?
                              device_address : 5'h00;
    end else if (reg_wr && reg_sel == REG_FREQ_PHASE &&
                 st_q == PIL_IDLE && !load_converter) begin
      fp_d[ILV_MSB:ILV_LSB] = reg_wdata[ILV_MSB:ILV_LSB];
      if (reg_wdata[FRQ_MSB:FRQ_LSB] == FRQ_500 ||
          reg_wdata[FRQ_MSB:FRQ_LSB] == FRQ_750 ||
          reg_wdata[FRQ_MSB:FRQ_LSB] == FRQ_1000) begin
        fp_d[FRQ_MSB:FRQ_LSB] = reg_wdata[FRQ_MSB:FRQ_LSB];
      end
    end else if (reg_wr && reg_sel == REG_DUTY_CAP) begin
      dc_d = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fp_q <= FP_RESET;
      dc_q <= DC_RESET;
      strap_q <= 1'b0;
    end else begin
      fp_q <= fp_d;
      dc_q <= dc_d;
      strap_q <= strap_d;
    end
  end

  // Period of the active frequency; own setting only
  always_comb begin
    unique case (frq_q)
      FRQ_750: begin
        base = PER1;
        rem = REM1;
        den = DEN1;
      end
      FRQ_1000: begin
        base = PER2;
        rem = REM2;
        den = DEN2;
      end
      default: begin
        base = PER0;
        rem = REM0;
        den = DEN0;
      end
    endcase
  end

  // Saturation window and duty products
  assign hi_sat = dc_q[HI_BIT] && reg_error > WINDOW_LIM;
  assign lo_sat = dc_q[LO_BIT] && reg_error < -WINDOW_LIM;
  assign cap_acc = ACC_W'({dc_q[CAP_MSB:CAP_LSB], 8'h00});
  assign dprod = (PER_W+6)'(dnext[ACC_W-1:ACC_FRAC]) * (PER_W+6)'(base);
  assign oprod = (PER_W+5)'(ilv_q) * (PER_W+5)'(base);
  assign wrap = (pos_q == per_q - PER_W'(1));
  assign sum = (ACC_W+1)'(dacc_q) +
               ((ACC_W+1)'(reg_error) <<< GAIN_SHIFT);

  // Next duty accumulator: jump on saturation, else integrate and clamp
  assign dnext = hi_sat ? cap_acc :
                 lo_sat ? {ACC_W{1'b0}} :
                 sum[ACC_W] ? (reg_error[7] ? {ACC_W{1'b0}} : cap_acc) :
                 (sum[ACC_W-1:0] > cap_acc) ? cap_acc :
                 sum[ACC_W-1:0];
  assign rel = (pos_q >= off_q) ? pos_q - off_q : pos_q + per_q - off_q;

  // Sequencing, divider, duty loop and PWM output
  always_comb begin
    st_d = st_q;
    frq_d = frq_q;
    ilv_d = ilv_q;
    pos_d = pos_q;
    per_d = per_q;
    acc_d = acc_q;
    off_d = off_q;
    dacc_d = dacc_q;
    duty_d = duty_q;
    pwm_d = 1'b0;
    unique case (st_q)
      PIL_IDLE: begin
        dacc_d = '0;
        duty_d = '0;
        if (load_converter) begin
          frq_d = fp_q[FRQ_MSB:FRQ_LSB];
          ilv_d = fp_q[ILV_MSB:ILV_LSB];
          st_d = PIL_WAIT_LOCK;
        end
      end
      PIL_WAIT_LOCK: begin
        off_d = PER_W'(oprod >> ILV_SHIFT);
        per_d = base;
        if (!load_converter) begin
          st_d = PIL_IDLE;
        end else if (locked && sync_edge) begin
          pos_d = '0;
          acc_d = rem;
          st_d = PIL_RUN;
        end
      end
      PIL_RUN: begin
        if (sync_edge) begin
          pos_d = '0;
          acc_d = rem; // Preload: long period ends on the sync edge
          per_d = base;
        end else if (wrap) begin
          pos_d = '0;
          // Fractional divider spreads the remainder
          if (acc_q + rem >= den) begin
            acc_d = acc_q + rem - den;
            per_d = base + PER_W'(1);
          end else begin
            acc_d = acc_q + rem;
            per_d = base;
          end
        end else begin
          pos_d = pos_q + PER_W'(1);
        end
        if (wrap || sync_edge) begin
          // New duty acts in the very next switching cycle
          dacc_d = dnext;
          duty_d = PER_W'(dprod / DUTY_DEN);
        end
        pwm_d = (rel < duty_q);
        if (!load_converter) begin
          st_d = PIL_IDLE;
          pwm_d = 1'b0;
        end else if (!locked) begin
          st_d = PIL_WAIT_LOCK;
          pwm_d = 1'b0;
        end
      end
      default: st_d = PIL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= PIL_IDLE;
      frq_q <= FRQ_500;
      ilv_q <= '0;
      pos_q <= '0;
      per_q <= PER0;
      acc_q <= '0;
      off_q <= '0;
      dacc_q <= '0;
      duty_q <= '0;
      pwm_q <= 1'b0;
      lk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      frq_q <= frq_d;
      ilv_q <= ilv_d;
      pos_q <= pos_d;
      per_q <= per_d;
      acc_q <= acc_d;
      off_q <= off_d;
      dacc_q <= dacc_d;
      duty_q <= duty_d;
      pwm_q <= pwm_d;
      lk_q <= locked;
    end
  end

  assign switch_frequency_phase = fp_q;
  assign duty_cap_saturation_ctrl = dc_q;
  assign pwm_out = pwm_q;
  assign pll_locked = lk_q;
endmodule

// ==== pil_asserts.sv ====
module pil_asserts
  import pil_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Inputs
  input wire logic sync_line,
  input wire logic load_converter,
  input wire logic phase_default_select_input,
  input wire logic [4:0] device_address,
  input wire logic signed [7:0] reg_error,
  input wire logic reg_wr,
  input wire logic reg_sel,
  input wire logic [7:0] reg_wdata,
  // Outputs
  input wire logic [7:0] switch_frequency_phase,
  input wire logic [7:0] duty_cap_saturation_ctrl,
  input wire logic pwm_out,
  input wire logic pll_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  int per;
  logic [10:0] hi_d, hi_q, gap_d, gap_q, lo_d, lo_q, lim;
  logic sy_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Run lengths of pwm high, sync silence and low saturation
  always_comb begin
    per = switch_frequency_phase[5] ? 334 :
      (switch_frequency_phase[6] ? 250 : 500);
    lim = 11'(duty_cap_saturation_ctrl[7:2] * per / 192);
    hi_d = pwm_out ? hi_q + 11'h001 : 11'h000;
    gap_d = gap_q + 11'(gap_q < 11'h7FF);
    if (sync_line && !sy_q) begin
      gap_d = 11'h000;
    end
    lo_d = lo_q + 11'(lo_q < 11'h7FF);
    if (!load_converter || !duty_cap_saturation_ctrl[0] ||
        reg_error > -8'sh21) begin
      lo_d = 11'h000;
    end
  end
  // Counter registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_q <= 11'h000;
      gap_q <= 11'h000;
      lo_q <= 11'h000;
      sy_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      gap_q <= gap_d;
      lo_q <= lo_d;
      sy_q <= sync_line;
    end
  end
  a_freq_held_on: assert property (
    reg_wr && !reg_sel && load_converter |=> $stable(switch_frequency_phase))
    else $error("freq reg changed while on");
  a_resv_code_kept: assert property (
    reg_wr && !reg_sel && reg_wdata[7:5] > 3'h2
    |=> $stable(switch_frequency_phase[7:5])) else $error("reserved code");
  a_freq_code_legal: assert property (
    switch_frequency_phase[7:5] <= 3'h2) else $error("bad freq code");
  a_duty_write_lands: assert property (
    reg_wr && reg_sel |=> duty_cap_saturation_ctrl == $past(reg_wdata))
    else $error("duty reg write lost");
  a_strap_load: assert property (
    $past(rst) && !rst |=> switch_frequency_phase[4:0] ==
    ($past(phase_default_select_input) ? $past(device_address) : 5'h00))
    else $error("strap load wrong");
  a_idle_no_pwm: assert property (
    (!pll_locked || !load_converter) [*2] |-> !pwm_out)
    else $error("pwm while off");
  a_duty_cap_max: assert property (
    pwm_out |-> hi_q < lim) else $error("duty above cap");
  a_low_sat_zero: assert property (
    lo_q > 11'h44C |-> !pwm_out) else $error("low saturation ignored");
  a_lock_drops: assert property (
    gap_q > 11'h3FC |-> !pll_locked) else $error("lock kept");
endmodule

// ==== pil_master.sv ====
module pil_master #(
  parameter int HALF = 500
) (
  // Clock and enable
  input wire logic sys_clk,
  input wire logic run,
  // Master clock
  output logic sync_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Square master clock, held low while stopped
  initial begin
    sync_line = 1'b0;
    cnt = 0;
    forever begin
      @(posedge sys_clk);
      #1;
      cnt = run ? (cnt + 1) % HALF : 0;
      if (cnt == 0) sync_line = run & ~sync_line;
    end
  end
endmodule

// ==== pwm_interleave_duty_limit_test.sv ====
module pwm_interleave_duty_limit_test import pil_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, sync_line, load_converter, reg_wr, reg_sel, run;
  logic phase_default_select_input, pwm_out, pll_locked;
  logic [4:0] device_address;
  logic signed [7:0] reg_error;
  logic [7:0] reg_wdata, switch_frequency_phase, duty_cap_saturation_ctrl, d;
  int failures, total_checks, m_fp, m_dc, n, d0, a, i;
  pil_master u_pil_master (.sys_clk, .run, .sync_line);
  pil_pwm u_pil_pwm (.sys_clk, .rst, .sync_line, .load_converter,
    .phase_default_select_input, .device_address, .reg_error, .reg_wr,
    .reg_sel, .reg_wdata, .switch_frequency_phase, .duty_cap_saturation_ctrl,
    .pwm_out, .pll_locked);
  // Compare and count
  task automatic chk(input logic [10:0] got, input int exp);
    total_checks++;
    if (got !== 11'(exp)) begin
      failures++;
      $display("wrong value at %0t: %h %h", $time, got, 11'(exp));
    end
  endtask
  // Verdict
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Register write with model update
  task automatic wr(input logic s, input logic [7:0] v);
    reg_sel = s;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    if (s) m_dc = v;
    else if (!load_converter) m_fp = v[7:5] > 2 ? {m_fp[7:5], v[4:0]} : v;
    @(posedge sys_clk);
    #1;
    chk(switch_frequency_phase, m_fp);
    chk(duty_cap_saturation_ctrl, m_dc);
  endtask
  task automatic do_reset(input logic s);
    rst = 1'b1;
    phase_default_select_input = s;
    device_address = 5'($urandom);
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    @(posedge sys_clk);
    #1;
    m_fp = s ? device_address : 0;
    m_dc = 8'hE8;
    chk(switch_frequency_phase, m_fp);
    chk(duty_cap_saturation_ctrl, m_dc);
  endtask
  // High count and first rise over 250 cycles after a sync edge
  task automatic measure();
    for (i = 0; i < 3000 && sync_line; i++) @(posedge sys_clk);
    for (i = i; i < 3000 && !sync_line; i++) @(posedge sys_clk);
    if (i >= 3000) begin
      failures++;
      final_report();
    end
    n = 0;
    d0 = -1;
    for (i = 0; i < 250; i++) begin
      @(posedge sys_clk);
      #1;
      n += pwm_out;
      if (pwm_out && d0 < 0) d0 = i;
    end
  endtask
  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    {rst, run, load_converter, reg_wr, reg_sel} = 5'h10;
    {reg_wdata, reg_error, device_address} = 21'h000000;
    phase_default_select_input = 1'b0;
    failures = 0;
    total_checks = 0;
    n = $urandom(40351);
    do_reset(1'b1);
    do_reset(1'b0);
    for (a = 0; a < 8; a++) begin
      d = {a[2:0], 5'($urandom)};
      if (d[4:1] == 4'h5) d[4] = 1'b1;
      wr(1'b0, d);
      wr(1'b1, 8'($urandom));
    end
    wr(1'b0, 8'h40);
    wr(1'b1, 8'hC2);
    reg_error = 8'sh64;
    run = 1'b1;
    load_converter = 1'b1;
    for (i = 0; i < 9000 && pll_locked !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(pll_locked, 1);
    if (pll_locked !== 1'b1) final_report();
    wr(1'b0, 8'h20);
    repeat (1000) @(posedge sys_clk);
    measure();
    chk(n, (m_dc >> 2) * 250 / 192);
    a = d0;
    wr(1'b1, 8'hC1);
    reg_error = 8'sh9C;
    repeat (1000) @(posedge sys_clk);
    measure();
    chk(n, 0);
    load_converter = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    wr(1'b0, 8'h48);
    wr(1'b1, 8'hC2);
    reg_error = 8'sh64;
    load_converter = 1'b1;
    repeat (2500) @(posedge sys_clk);
    measure();
    chk(d0 - a, 8 * 250 / 32);
    // Lowest and middle frequency, no interleave
    for (a = 0; a < 2; a++) begin
      load_converter = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      wr(1'b0, {a[2:0], 5'h00});
      load_converter = 1'b1;
      repeat (2500) @(posedge sys_clk);
      measure();
      chk(n, (m_dc >> 2) * (a ? PER1 : PER0) / 192);
      chk(d0, 1);
    end
    run = 1'b0;
    repeat (1300) @(posedge sys_clk);
    #1;
    chk({pll_locked, pwm_out}, 0);
    final_report();
  end
endmodule
bind pil_pwm pil_asserts u_pil_asserts (
  .sys_clk(sys_clk),
  .rst(rst),
  .sync_line(sync_line),
  .load_converter(load_converter),
  .phase_default_select_input(phase_default_select_input),
  .device_address(device_address),
  .reg_error(reg_error),
  .reg_wr(reg_wr),
  .reg_sel(reg_sel),
  .reg_wdata(reg_wdata),
  .switch_frequency_phase(switch_frequency_phase),
  .duty_cap_saturation_ctrl(duty_cap_saturation_ctrl),
  .pwm_out(pwm_out),
  .pll_locked(pll_locked)
);
